// [shared/pmcw_defs.vh]
// Constants for the power mode, clock and wake-up controller.
`ifndef PMCW_DEFS_VH
`define PMCW_DEFS_VH

// Master clock rate.
`define PMCW_MCLK_MHZ        200
`define PMCW_MCLK_HZ         200000000

// Slow internal RC oscillator rate and its divider from the master clock.
`define PMCW_SLOW_OSC_HZ     32768
`define PMCW_SLOW_DIV        (`PMCW_MCLK_HZ / `PMCW_SLOW_OSC_HZ)

// Fast RC oscillator frequency codes (three configuration bits), in MHz.
`define PMCW_FAST_MHZ_0      1
`define PMCW_FAST_MHZ_1      2
`define PMCW_FAST_MHZ_2      4
`define PMCW_FAST_MHZ_3      8
`define PMCW_FAST_MHZ_4      16
`define PMCW_FAST_MHZ_5      20

// Instruction clock divide ratios.
`define PMCW_INSTR_DIV_LO    2
`define PMCW_INSTR_DIV_HI    4

// Halt wake-up stabilisation, in system clock cycles.
`define PMCW_WAKE_STABLE     16

// Oscillator control field positions.
`define PMCW_OSC_SEL_BIT     0
`define PMCW_OSC_STOP_BIT    1
`define PMCW_OSC_MODE_LO     2
`define PMCW_OSC_MODE_HI     3
`define PMCW_OSC_RESET       4'h0

// Power mode field codes.
`define PMCW_MODE_RUN        2'h0
`define PMCW_MODE_HALT       2'h1
`define PMCW_MODE_STANDBY    2'h2

// Interrupt flag positions.
`define PMCW_FLG_WDOG        0
`define PMCW_FLG_PORT        1
`define PMCW_FLG_EXT         2
`define PMCW_FLG_LVOLT       3

`endif

// [hdl/pmcw_tick_div.v]
// Enable divider: one tick out for every div input steps.
`timescale 1ns/1ps
`default_nettype none
module pmcw_tick_div #(
    parameter W = 16
) (
    // Clock and reset.
    input  wire         mclk,
    input  wire         rst_b,
    // Control.
    input  wire         run,
    input  wire         step,
    input  wire [W-1:0] div,
    // Output enable pulse.
    output reg          tick_q
);
    reg [W-1:0] cnt_q;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (step) begin
                if (cnt_q >= div - {{(W-1){1'b0}}, 1'b1}) begin
                    cnt_q  <= {W{1'b0}};
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/pmcw_flag.v]
// Sticky interrupt flag; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module pmcw_flag (
    // Clock and reset.
    input  wire mclk,
    input  wire rst_b,
    // Set and clear.
    input  wire set,
    input  wire clr,
    // Flag.
    output reg  flag_q
);
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [hdl/pmcw_top.v]
// Power mode, clock selection and wake-up controller.
// Behaviour
// - watchdog expiry in irq mode sets flag
// - enabled input pin change sets port flag
// - pin zero excluded while external select set
// - chosen edge on pin zero sets ext flag
// - low-voltage falling edge sets its flag
// - stop bit stops the fast oscillator
// - Halt entry disables fast oscillator automatically
// - fast oscillator rate from three config bits
// - select bit picks fast or slow clock
// - instruction clock is system clock /2 or /4
// - start Normal or Slow per startup config
// - mode field 10 Standby, 01 Halt; sleep halts
// - Halt entry: power-down 0, timeout 1, watchdog clear
// - Halt stops execution, peripherals, both oscillators
// - Halt wakes on watchdog, port, external only
// - Standby stops execution; six wake sources
// - Standby keeps timers per enable, slow oscillator
// - wake resumes Normal or Slow by select bit
// - Slow or Standby stop fast oscillator only via stop bit
// - Halt wake waits 16 system clocks
// - wake branches to vector if irqs enabled
// - slow clock routed to timer zero in Normal mode only
// - global enable gates service; instructions set/clear
// - flags stay set until written zero
`timescale 1ns/1ps
`default_nettype none
`include "pmcw_defs.vh"
module pmcw_top #(
    parameter SLOW_DIV = `PMCW_SLOW_DIV
) (
    // Clock and reset.
    input  wire       mclk,
    input  wire       rst_b,
    // Configuration words.
    input  wire [2:0] cfg_fast_freq,
    input  wire       cfg_instr_div4,
    input  wire       cfg_startup_fast,
    input  wire       cfg_wdog_irq_mode,
    input  wire       cfg_timer_zero_slow_src,
    // Processor side.
    input  wire       reset_done,
    input  wire       osc_ctrl_wr,
    input  wire [3:0] osc_ctrl_wdata,
    input  wire       sleep_instr,
    input  wire       irq_enable_instr,
    input  wire       irq_disable_instr,
    input  wire       flag_wr,
    input  wire [3:0] flag_wdata,
    // Interrupt enables and control bits.
    input  wire       wdog_irq_enable,
    input  wire       port_change_irq_enable,
    input  wire       ext_irq_enable,
    input  wire       low_volt_irq_enable,
    input  wire       ext_irq_select,
    input  wire       ext_edge_polarity,
    input  wire [5:0] port_change_wake_sel,
    input  wire       slow_clk_to_timer_zero,
    input  wire       timer_zero_enable,
    input  wire       timer_one_enable,
    // Event sources.
    input  wire       wdog_expire,
    input  wire [5:0] port_b_in,
    input  wire [5:0] port_b_is_input,
    input  wire       low_volt_out,
    input  wire       timer_zero_irq,
    input  wire       timer_one_irq,
    // Clock outputs.
    output reg        fast_osc_on_q,
    output reg        slow_osc_on_q,
    output reg        sys_tick_q,
    output wire       instr_tick_q,
    output reg        timer_zero_slow_tick_q,
    // Mode and status outputs.
    output reg  [3:0] osc_control_reg_q,
    output reg  [3:0] mode_q,
    output reg        cpu_run_q,
    output reg        periph_en_q,
    output reg        timer_zero_run_q,
    output reg        timer_one_run_q,
    output reg        power_down_n_status_q,
    output reg        timeout_n_status_q,
    output reg        wdog_clear_q,
    // Interrupt outputs.
    output reg        global_irq_enable_q,
    output wire [3:0] irq_flags_q,
    output reg        irq_req_q,
    output reg        irq_vector_q
);
    // Controller states.
    localparam [4:0] ST_RESET   = 5'h01;
    localparam [4:0] ST_RUN     = 5'h02;
    localparam [4:0] ST_STANDBY = 5'h04;
    localparam [4:0] ST_HALT    = 5'h08;
    localparam [4:0] ST_STABLE  = 5'h10;

    // Mode output encoding: Normal, Slow, Standby, Halt.
    localparam [3:0] MD_NORMAL  = 4'h1;
    localparam [3:0] MD_SLOW    = 4'h2;
    localparam [3:0] MD_STANDBY = 4'h4;
    localparam [3:0] MD_HALT    = 4'h8;

    // Fast oscillator period in master clocks for a frequency code.
    function [15:0] fast_div;
        input [2:0] code;
        begin
            case (code)
                3'h0:    fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_0;
                3'h1:    fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_1;
                3'h2:    fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_2;
                3'h3:    fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_3;
                3'h4:    fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_4;
                default: fast_div = `PMCW_MCLK_MHZ / `PMCW_FAST_MHZ_5;
            endcase
        end
    endfunction

    reg  [4:0] state_q;
    reg  [4:0] stable_cnt_q;
    reg  [5:0] port_prev_q;
    reg        lv_prev_q;
    reg        armed_q;
    wire       fast_tick;
    wire       slow_tick;
    wire       sel_fast  = osc_control_reg_q[`PMCW_OSC_SEL_BIT];
    wire       stop_fast = osc_control_reg_q[`PMCW_OSC_STOP_BIT];
    wire [1:0] wr_mode   =
        osc_ctrl_wdata[`PMCW_OSC_MODE_HI:`PMCW_OSC_MODE_LO];

    // Oscillator enables: Halt stops both, the stop bit stops fast only.
    wire fast_on_d = !stop_fast && (state_q != ST_HALT);
    wire slow_on_d = (state_q != ST_HALT);

    pmcw_tick_div #(.W(16)) u_fast_div (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .run    (fast_osc_on_q),
        .step   (1'b1),
        .div    (fast_div(cfg_fast_freq)),
        .tick_q (fast_tick)
    );

    pmcw_tick_div #(.W(16)) u_slow_div (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .run    (slow_osc_on_q),
        .step   (1'b1),
        .div    (SLOW_DIV[15:0]),
        .tick_q (slow_tick)
    );

    pmcw_tick_div #(.W(3)) u_instr_div (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .run    (fast_osc_on_q | slow_osc_on_q),
        .step   (sys_tick_q),
        .div    (cfg_instr_div4 ? 3'h4 : 3'h2),
        .tick_q (instr_tick_q)
    );

    // Event detection on port B, the external pin and the detector.
    wire [5:0] chg_mask = port_b_is_input & port_change_wake_sel &
                          {5'h1F, !ext_irq_select};
    wire port_set  = armed_q && |((port_b_in ^ port_prev_q) & chg_mask);
    wire rise0     = port_b_in[0] && !port_prev_q[0];
    wire fall0     = !port_b_in[0] && port_prev_q[0];
    wire ext_set   = armed_q && ext_irq_select &&
                     (ext_edge_polarity ? rise0 : fall0);
    wire lvolt_set = armed_q && lv_prev_q && !low_volt_out;
    wire wdog_set  = wdog_expire && cfg_wdog_irq_mode;

    wire [3:0] flag_set = {lvolt_set, ext_set, port_set, wdog_set};
    wire [3:0] flag_en  = {low_volt_irq_enable, ext_irq_enable,
                           port_change_irq_enable, wdog_irq_enable};
    wire [3:0] flag_clr = {4{flag_wr}} & ~flag_wdata;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            pmcw_flag u_flag (
                .mclk   (mclk),
                .rst_b  (rst_b),
                .set    (flag_set[gi]),
                .clr    (flag_clr[gi]),
                .flag_q (irq_flags_q[gi])
            );
        end
    endgenerate

    // Wake sources per sleeping mode.
    wire [3:0] ev_en     = flag_set & flag_en;
    wire       halt_wake = ev_en[`PMCW_FLG_WDOG] | ev_en[`PMCW_FLG_PORT] |
                           ev_en[`PMCW_FLG_EXT];
    wire       stby_wake = |ev_en | timer_zero_irq | timer_one_irq;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port_prev_q <= 6'h00;
            lv_prev_q   <= 1'b0;
            armed_q     <= 1'b0;
        end else begin
            port_prev_q <= port_b_in;
            lv_prev_q   <= low_volt_out;
            armed_q     <= 1'b1;
        end
    end

    // Mode sequencer.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q               <= ST_RESET;
            osc_control_reg_q     <= `PMCW_OSC_RESET;
            stable_cnt_q          <= 5'h00;
            power_down_n_status_q <= 1'b1;
            timeout_n_status_q    <= 1'b1;
            wdog_clear_q          <= 1'b0;
            global_irq_enable_q   <= 1'b0;
            irq_vector_q          <= 1'b0;
        end else begin
            wdog_clear_q <= 1'b0;
            irq_vector_q <= 1'b0;
            if (irq_enable_instr) begin
                global_irq_enable_q <= 1'b1;
            end else if (irq_disable_instr) begin
                global_irq_enable_q <= 1'b0;
            end
            if (wdog_expire) begin
                timeout_n_status_q <= 1'b0;
            end
            case (state_q)
                ST_RESET: begin
                    if (reset_done) begin
                        osc_control_reg_q[`PMCW_OSC_SEL_BIT] <=
                            cfg_startup_fast;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sleep_instr ||
                        (osc_ctrl_wr && wr_mode == `PMCW_MODE_HALT)) begin
                        if (osc_ctrl_wr) begin
                            osc_control_reg_q <= osc_ctrl_wdata;
                        end
                        osc_control_reg_q[`PMCW_OSC_MODE_HI:
                                          `PMCW_OSC_MODE_LO] <=
                            `PMCW_MODE_HALT;
                        power_down_n_status_q <= 1'b0;
                        timeout_n_status_q    <= 1'b1;
                        wdog_clear_q          <= 1'b1;
                        state_q               <= ST_HALT;
                    end else if (osc_ctrl_wr) begin
                        osc_control_reg_q <= osc_ctrl_wdata;
                        if (wr_mode == `PMCW_MODE_STANDBY) begin
                            state_q <= ST_STANDBY;
                        end
                    end
                end
                ST_STANDBY: begin
                    if (stby_wake) begin
                        osc_control_reg_q[`PMCW_OSC_MODE_HI:
                                          `PMCW_OSC_MODE_LO] <=
                            `PMCW_MODE_RUN;
                        irq_vector_q <= global_irq_enable_q;
                        state_q      <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (halt_wake) begin
                        stable_cnt_q <= 5'h00;
                        state_q      <= ST_STABLE;
                    end
                end
                ST_STABLE: begin
                    if (sys_tick_q) begin
                        stable_cnt_q <= stable_cnt_q + 5'h01;
                    end
                    if (stable_cnt_q == `PMCW_WAKE_STABLE) begin
                        osc_control_reg_q[`PMCW_OSC_MODE_HI:
                                          `PMCW_OSC_MODE_LO] <=
                            `PMCW_MODE_RUN;
                        irq_vector_q <= global_irq_enable_q;
                        state_q      <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
            if (irq_vector_q) begin
                global_irq_enable_q <= 1'b0;
            end
        end
    end

    // Registered clock, mode and gating outputs.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fast_osc_on_q          <= 1'b1;
            slow_osc_on_q          <= 1'b1;
            sys_tick_q             <= 1'b0;
            timer_zero_slow_tick_q <= 1'b0;
            mode_q                 <= MD_NORMAL;
            cpu_run_q              <= 1'b0;
            periph_en_q            <= 1'b0;
            timer_zero_run_q       <= 1'b0;
            timer_one_run_q        <= 1'b0;
            irq_req_q              <= 1'b0;
        end else begin
            fast_osc_on_q <= fast_on_d;
            slow_osc_on_q <= slow_on_d;
            sys_tick_q    <= sel_fast ? fast_tick : slow_tick;
            timer_zero_slow_tick_q <= slow_tick && sel_fast &&
                slow_clk_to_timer_zero && cfg_timer_zero_slow_src &&
                (state_q == ST_RUN);
            case (state_q)
                ST_STANDBY: mode_q <= MD_STANDBY;
                ST_HALT:    mode_q <= MD_HALT;
                ST_STABLE:  mode_q <= MD_HALT;
                default:    mode_q <= sel_fast ? MD_NORMAL : MD_SLOW;
            endcase
            cpu_run_q        <= (state_q == ST_RUN);
            periph_en_q      <= (state_q != ST_HALT) &&
                                (state_q != ST_STABLE);
            timer_zero_run_q <= timer_zero_enable &&
                                (state_q != ST_HALT);
            timer_one_run_q  <= timer_one_enable &&
                                (state_q != ST_HALT);
            irq_req_q        <= global_irq_enable_q &&
                                |(irq_flags_q & flag_en);
        end
    end
endmodule
`default_nettype wire

// [testbench/pmcw_top_asserts.sv]
// Concurrent checks on the power mode and wake-up controller ports.
`timescale 1ns/1ps
`default_nettype none
module pmcw_top_asserts (
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       rst_b,
    // Stimulus side.
    input wire logic       cfg_wdog_irq_mode,
    input wire logic       osc_ctrl_wr,
    input wire logic [3:0] osc_ctrl_wdata,
    input wire logic       sleep_instr,
    input wire logic       irq_enable_instr,
    input wire logic       flag_wr,
    input wire logic       wdog_irq_enable,
    input wire logic       port_change_irq_enable,
    input wire logic       ext_irq_enable,
    input wire logic       low_volt_irq_enable,
    input wire logic       wdog_expire,
    input wire logic       low_volt_out,
    // Design outputs.
    input wire logic       fast_osc_on_q,
    input wire logic       slow_osc_on_q,
    input wire logic [3:0] osc_control_reg_q,
    input wire logic [3:0] mode_q,
    input wire logic       cpu_run_q,
    input wire logic       power_down_n_status_q,
    input wire logic       global_irq_enable_q,
    input wire logic [3:0] irq_flags_q,
    input wire logic       irq_req_q,
    input wire logic       irq_vector_q
);
    wire [3:0] en = {low_volt_irq_enable, ext_irq_enable,
                     port_change_irq_enable, wdog_irq_enable};
    wire slowish = mode_q[1] || mode_q[2];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_WDOG_FLAG: assert property (
        wdog_expire && cfg_wdog_irq_mode |=> irq_flags_q[0])
        else $error("no watchdog flag");
    AST_LVOLT_FLAG: assert property (
        $past(rst_b) && $fell(low_volt_out) |=> irq_flags_q[3])
        else $error("no low-voltage flag");
    AST_FLAG_STICKY: assert property (
        !flag_wr |=> (irq_flags_q & $past(irq_flags_q)) == $past(irq_flags_q))
        else $error("flag lost");
    AST_IRQ_REQ: assert property (
        irq_req_q == $past(global_irq_enable_q && |(irq_flags_q & en)))
        else $error("bad request");
    AST_HALT_ENTRY: assert property (
        $rose(mode_q[3]) |-> ##[0:2]
        (!power_down_n_status_q && !fast_osc_on_q && !slow_osc_on_q))
        else $error("bad halt entry");
    AST_STANDBY_ENTRY: assert property (
        osc_ctrl_wr && cpu_run_q && !sleep_instr && osc_ctrl_wdata[3:2] == 2'h2
        && !$past(osc_ctrl_wr || sleep_instr) |-> ##2 mode_q == 4'h4)
        else $error("standby not entered");
    AST_STANDBY_QUIET: assert property (
        mode_q[2] |-> !cpu_run_q)
        else $error("running in standby");
    AST_FAST_KEPT: assert property (
        slowish && $past(slowish) && !osc_control_reg_q[1]
        && !$past(osc_control_reg_q[1]) |-> fast_osc_on_q)
        else $error("fast clock stopped");
    AST_STOP: assert property (
        $past(osc_control_reg_q[1]) |-> !fast_osc_on_q)
        else $error("fast clock runs");
    AST_VECTOR: assert property (
        irq_vector_q && !irq_enable_instr |=>
        !irq_vector_q && !global_irq_enable_q)
        else $error("bad vector pulse");

    COV_STANDBY: cover property ($rose(mode_q[2]));
    COV_HALT: cover property ($rose(mode_q[3]));
    COV_VECTOR: cover property (irq_vector_q);
endmodule
bind pmcw_top pmcw_top_asserts i_pmcw_top_asserts (
    .mclk, .rst_b, .cfg_wdog_irq_mode, .osc_ctrl_wr, .osc_ctrl_wdata,
    .sleep_instr, .irq_enable_instr, .flag_wr, .wdog_irq_enable,
    .port_change_irq_enable, .ext_irq_enable, .low_volt_irq_enable,
    .wdog_expire, .low_volt_out, .fast_osc_on_q, .slow_osc_on_q,
    .osc_control_reg_q, .mode_q, .cpu_run_q, .power_down_n_status_q,
    .global_irq_enable_q, .irq_flags_q, .irq_req_q, .irq_vector_q
);
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the power mode and wake-up controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SDIV = 8;
    logic mclk, rst_b, reset_done, cfg_instr_div4, cfg_startup_fast;
    logic cfg_wdog_irq_mode, cfg_timer_zero_slow_src, osc_ctrl_wr, flag_wr;
    logic sleep_instr, irq_enable_instr, irq_disable_instr, wdog_expire;
    logic wdog_irq_enable, port_change_irq_enable, ext_irq_enable;
    logic low_volt_irq_enable, ext_irq_select, ext_edge_polarity;
    logic slow_clk_to_timer_zero, timer_zero_enable, timer_one_enable;
    logic low_volt_out, timer_zero_irq, timer_one_irq;
    logic [2:0] cfg_fast_freq;
    logic [3:0] osc_ctrl_wdata, flag_wdata;
    logic [5:0] port_change_wake_sel, port_b_in, port_b_is_input;
    wire fast_osc_on_q, slow_osc_on_q, sys_tick_q, instr_tick_q;
    wire timer_zero_slow_tick_q, cpu_run_q, periph_en_q, timer_zero_run_q;
    wire timer_one_run_q, power_down_n_status_q, timeout_n_status_q;
    wire wdog_clear_q, global_irq_enable_q, irq_req_q, irq_vector_q;
    wire [3:0] osc_control_reg_q, mode_q, irq_flags_q;
    int mismatches, n_compared, n_vec, c, v;
    int mhz[6] = '{1, 2, 4, 8, 16, 20};
    logic [31:0] rng_q, r;
    logic [2:0] ev;

    pmcw_top #(.SLOW_DIV(SDIV)) i_pmcw_top (
        .mclk, .rst_b, .cfg_fast_freq, .cfg_instr_div4, .cfg_startup_fast,
        .cfg_wdog_irq_mode, .cfg_timer_zero_slow_src, .reset_done,
        .osc_ctrl_wr, .osc_ctrl_wdata, .sleep_instr, .irq_enable_instr,
        .irq_disable_instr, .flag_wr, .flag_wdata, .wdog_irq_enable,
        .port_change_irq_enable, .ext_irq_enable, .low_volt_irq_enable,
        .ext_irq_select, .ext_edge_polarity, .port_change_wake_sel,
        .slow_clk_to_timer_zero, .timer_zero_enable, .timer_one_enable,
        .wdog_expire, .port_b_in, .port_b_is_input, .low_volt_out,
        .timer_zero_irq, .timer_one_irq, .fast_osc_on_q, .slow_osc_on_q,
        .sys_tick_q, .instr_tick_q, .timer_zero_slow_tick_q,
        .osc_control_reg_q, .mode_q, .cpu_run_q, .periph_en_q,
        .timer_zero_run_q, .timer_one_run_q, .power_down_n_status_q,
        .timeout_n_status_q, .wdog_clear_q, .global_irq_enable_q,
        .irq_flags_q, .irq_req_q, .irq_vector_q
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (irq_vector_q === 1'b1) n_vec++;
    end

    function automatic logic [31:0] rnd();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wr_osc(input logic [3:0] d);
        osc_ctrl_wdata = d;
        osc_ctrl_wr = 1'b1;
        tick(1);
        osc_ctrl_wr = 1'b0;
        tick(3);
    endtask

    task automatic clr_flags(input logic [3:0] d);
        flag_wdata = d;
        flag_wr = 1'b1;
        tick(1);
        flag_wr = 1'b0;
        tick(1);
    endtask

    // Settled period, in cycles, of the system or instruction tick.
    task automatic gap(input bit ins, output int n);
        repeat (3) begin
            n = 0;
            do begin
                tick(1);
                n++;
            end while ((ins ? instr_tick_q : sys_tick_q) !== 1'b1 && n < 4000);
        end
    endtask

    task automatic wait_left(output int n);
        n = 0;
        while (mode_q === 4'h8 && n < 2000) begin
            tick(1);
            n++;
        end
    endtask

    task automatic do_reset(input logic fast);
        rst_b = 1'b0;
        reset_done = 1'b0;
        cfg_startup_fast = fast;
        tick(4);
        rst_b = 1'b1;
        tick(2);
        reset_done = 1'b1;
        tick(4);
        check(mode_q, fast ? 4'h1 : 4'h2);
        check(osc_control_reg_q, {3'h0, fast});
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        complete_run;
    end

    initial begin
        {rst_b, reset_done, cfg_instr_div4, cfg_startup_fast, osc_ctrl_wr,
         cfg_wdog_irq_mode, cfg_timer_zero_slow_src, flag_wr, sleep_instr,
         irq_enable_instr, irq_disable_instr, wdog_expire, wdog_irq_enable,
         port_change_irq_enable, ext_irq_enable, low_volt_irq_enable,
         ext_irq_select, ext_edge_polarity, slow_clk_to_timer_zero,
         timer_zero_enable, timer_one_enable, timer_zero_irq,
         timer_one_irq, cfg_fast_freq, osc_ctrl_wdata, flag_wdata,
         port_change_wake_sel, port_b_in, port_b_is_input} = '0;
        low_volt_out = 1'b1;
        rng_q = 32'h24B3FECF;
        do_reset(1'b1);
        for (int i = 0; i < 6; i++) begin
            cfg_fast_freq = 3'(i);
            cfg_instr_div4 = i[0];
            gap(1'b0, c);
            check(c, 200 / mhz[i]);
            gap(1'b1, v);
            check(v, c * (i[0] ? 4 : 2));
        end
        done("clock rates");
        {slow_clk_to_timer_zero, cfg_timer_zero_slow_src} = 2'h3;
        v = 0;
        repeat (4 * SDIV) begin
            tick(1);
            if (timer_zero_slow_tick_q === 1'b1) v++;
        end
        check(v, 4);
        done("timer routing");
        wr_osc(4'h0);
        check(mode_q, 4'h2);
        gap(1'b0, c);
        check(c, SDIV);
        check(fast_osc_on_q, 1'b1);
        wr_osc(4'h2);
        check(fast_osc_on_q, 1'b0);
        done("slow mode");
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            {port_change_wake_sel, port_b_is_input} = r[11:0];
            {ext_edge_polarity, ext_irq_select} = r[13:12];
            cfg_wdog_irq_mode = r[21];
            tick(1);
            clr_flags(4'h0);
            v = r[18:16] % 6;
            port_b_in[v] = ~port_b_in[v];
            wdog_expire = r[20];
            tick(1);
            wdog_expire = 1'b0;
            tick(2);
            ev[0] = r[20] & r[21];
            ev[1] = r[v + 6] & r[v] & !(v == 0 && r[12]);
            ev[2] = v == 0 && r[12] && port_b_in[0] == r[13];
            check(irq_flags_q[2:0], ev);
        end
        done("flag events");
        clr_flags(4'h0);
        {low_volt_irq_enable, low_volt_out} = 2'h2;
        tick(2);
        check(irq_flags_q[3], 1'b1);
        irq_enable_instr = 1'b1;
        tick(1);
        irq_enable_instr = 1'b0;
        tick(2);
        check(irq_req_q, 1'b1);
        clr_flags(4'hF);
        check(irq_flags_q[3], 1'b1);
        clr_flags(4'h7);
        tick(1);
        check({irq_flags_q[3], irq_req_q}, 2'h0);
        irq_disable_instr = 1'b1;
        tick(1);
        irq_disable_instr = 1'b0;
        tick(1);
        check(global_irq_enable_q, 1'b0);
        irq_enable_instr = 1'b1;
        tick(1);
        irq_enable_instr = 1'b0;
        {low_volt_irq_enable, low_volt_out} = 2'h1;
        done("interrupt enables");
        timer_zero_enable = 1'b1;
        wr_osc(4'hA);
        check({mode_q, cpu_run_q}, {4'h4, 1'b0});
        check({slow_osc_on_q, timer_zero_run_q, timer_one_run_q},
              3'h6);
        v = n_vec;
        timer_zero_irq = 1'b1;
        tick(1);
        timer_zero_irq = 1'b0;
        tick(4);
        check(mode_q, 4'h2);
        check(osc_control_reg_q[3:2], 2'h0);
        check(n_vec - v, 1);
        done("standby");
        sleep_instr = 1'b1;
        tick(1);
        sleep_instr = 1'b0;
        check(wdog_clear_q, 1'b1);
        tick(3);
        check({mode_q, power_down_n_status_q, timeout_n_status_q},
              {4'h8, 2'h1});
        check({slow_osc_on_q, periph_en_q, cpu_run_q}, 3'h0);
        {low_volt_irq_enable, low_volt_out, timer_zero_irq,
         timer_one_irq} = 4'hB;
        tick(1);
        {timer_zero_irq, timer_one_irq} = 2'h0;
        tick(20);
        check(mode_q, 4'h8);
        low_volt_out = 1'b1;
        {wdog_irq_enable, cfg_wdog_irq_mode} = 2'h3;
        v = n_vec;
        wdog_expire = 1'b1;
        tick(1);
        wdog_expire = 1'b0;
        wait_left(c);
        check(c >= 15 * SDIV && c <= 16 * SDIV + 8, 1);
        tick(2);
        check({mode_q, cpu_run_q}, {4'h2, 1'b1});
        check(n_vec - v, 0);
        done("halt by sleep");
        wdog_irq_enable = 1'b0;
        do_reset(1'b0);
        wr_osc(4'h4);
        check({mode_q, fast_osc_on_q}, {4'h8, 1'b0});
        ext_irq_select = 1'b0;
        {port_b_is_input, port_change_wake_sel} = 12'h041;
        port_change_irq_enable = 1'b1;
        port_b_in[0] = ~port_b_in[0];
        wait_left(c);
        tick(2);
        check(mode_q, 4'h2);
        done("halt by field");
        complete_run;
    end
endmodule
`default_nettype wire
